/* rtl/starter_status_pkg.sv */
// How it works
// [RULE1] bit 0 is high while the motor is enabled, low otherwise
// [RULE2] bit 1 is high only when every command source grants general enable
// [RULE3] bit 2 is high while the jog function is active
// [RULE4] bit 3 is high only while initial tests run before a start
// [RULE5] bit 4 high for whole acceleration ramp, bit 7 for whole deceleration
// [RULE6] bit 5 is high while full voltage is applied to the motor
// [RULE7] bit 6 is high when the bypass contactor is closed
// [RULE8] bit 8 is low for local operation, high for remote operation
// [RULE9] bit 9 is high for the duration of a braking process
// [RULE10] bit 10 is high only while a rotation reversal is in progress
// [RULE11] bit 11 is low for forward rotation, high for reverse rotation
// [RULE12] bit 12 is high while the delay before a start is elapsing
// [RULE13] bit 13 is high while the delay after a stop is elapsing
// [RULE14] bit 14 is high while any alarm is present; codes readable apart
// [RULE15] bit 15 is high while a fault is present; code readable apart
// [RULE16] module state led is steady green in normal operation
// [RULE17] led is steady red on error and stays so until reinitialised
// [RULE18] led flashes green and red alternately during self-diagnosis
// [RULE19] node address is settable from 1 to 127, unique on the network
// [RULE20] bit rate is one of nine values from 10 kbit/s to 1 Mbit/s
// [RULE21] the status word is rebuilt every cycle and is read-only
package starter_status_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam logic [3:0] addr_status = 4'h0;
    localparam logic [3:0] addr_alarm = 4'h4;
    localparam logic [3:0] addr_fault = 4'h8;
    localparam logic [3:0] addr_node = 4'hC;
    localparam int addr_width = 4;

    // ------------------------------------------------------------
    // status word bit positions
    // ------------------------------------------------------------
    localparam int bit_running = 0;
    localparam int bit_gen_enable = 1;
    localparam int bit_jog = 2;
    localparam int bit_init_test = 3;
    localparam int bit_ramp_up = 4;
    localparam int bit_full_volt = 5;
    localparam int bit_bypass = 6;
    localparam int bit_ramp_down = 7;
    localparam int bit_remote = 8;
    localparam int bit_braking = 9;
    localparam int bit_reversing = 10;
    localparam int bit_reverse = 11;
    localparam int bit_pre_start = 12;
    localparam int bit_post_stop = 13;
    localparam int bit_alarm = 14;
    localparam int bit_fault = 15;

    // ------------------------------------------------------------
    // node configuration register fields and reset values
    // ------------------------------------------------------------
    localparam int node_lsb = 0;
    localparam int node_msb = 6;
    localparam int rate_lsb = 8;
    localparam int rate_msb = 11;
    localparam logic [6:0] node_min = 7'h01;
    localparam logic [6:0] node_max = 7'h7F;
    localparam logic [6:0] node_reset = 7'h01;
    localparam logic [3:0] rate_reset = 4'h0;
    localparam logic [3:0] rate_last = 4'h8;

    // bit rate selection codes
    typedef enum logic [3:0] {
        rate_10k = 4'h0,
        rate_20k = 4'h1,
        rate_50k = 4'h2,
        rate_100k = 4'h3,
        rate_125k = 4'h4,
        rate_250k = 4'h5,
        rate_500k = 4'h6,
        rate_800k = 4'h7,
        rate_1m = 4'h8
    } bit_rate_t;

    // ------------------------------------------------------------
    // led encoding and timing
    // ------------------------------------------------------------
    localparam logic [1:0] led_off = 2'h0;
    localparam logic [1:0] led_green = 2'h1;
    localparam logic [1:0] led_red = 2'h2;
    localparam int clock_hz = 50_000_000;
    localparam int flash_ms = 250;
    localparam int flash_cycles = clock_hz / 1000 * flash_ms;

endpackage : starter_status_pkg

/* rtl/led_flasher.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// toggles a phase bit every half_period cycles while run is high
// ------------------------------------------------------------
module led_flasher #(
    parameter int half_period = starter_status_pkg::flash_cycles
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // control
    input wire logic run,
    // phase out
    output logic phase
);
    typedef struct packed {
        logic [31:0] count;
        logic phase;
    } flash_state_t;

    flash_state_t state;
    flash_state_t next_state;

    // restart from the green phase whenever flashing stops
    always_comb begin
        next_state = state;
        if (!run) begin
            next_state.count = 32'h0000_0000;
            next_state.phase = 1'b0;
        end else if (state.count >= 32'(half_period - 1)) begin
            next_state.count = 32'h0000_0000;
            next_state.phase = !state.phase;
        end else begin
            next_state.count = state.count + 32'h0000_0001;
        end
    end

    // state register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign phase = state.phase;
endmodule : led_flasher
`default_nettype wire

/* rtl/starter_status_word_and_led.sv */
// Decided for this implementation: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// status word assembly, module led and node settings
// ------------------------------------------------------------
module starter_status_word_and_led #(
    parameter int source_count = 3,
    parameter int flash_half = starter_status_pkg::flash_cycles
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic [1:0] response,
    // drive state
    input wire logic motor_enabled,
    input wire logic [source_count-1:0] source_enable,
    input wire logic jog_active,
    input wire logic initial_test,
    input wire logic ramp_up,
    input wire logic full_voltage,
    input wire logic bypass_closed,
    input wire logic ramp_down,
    input wire logic remote_mode,
    input wire logic braking,
    input wire logic reversal_in_progress,
    input wire logic reverse_rotation,
    input wire logic pre_start_delay_flag,
    input wire logic post_stop_delay_flag,
    input wire logic [15:0] alarm_codes,
    input wire logic [15:0] fault_code,
    // module health
    input wire logic self_diagnosis,
    input wire logic module_error,
    // indicator and node settings
    output logic [1:0] module_state_led,
    output logic [6:0] node_address,
    output logic [3:0] bit_rate
);
    typedef struct packed {
        logic [15:0] status;
        logic [31:0] rdata;
        logic waiting;
        logic [1:0] resp;
        logic [1:0] led;
        logic error_latched;
        logic [6:0] node;
        logic [3:0] rate;
    } top_state_t;

    top_state_t state;
    top_state_t next_state;
    logic flash_phase;

    // clamp a requested node address into the legal range
    function automatic logic [6:0] clamp_node(input logic [6:0] value);
        if (value < starter_status_pkg::node_min) begin
            return starter_status_pkg::node_min;
        end
        return value;
    endfunction : clamp_node

    // only the nine listed rate codes are legal
    function automatic logic rate_legal(input logic [3:0] code);
        return code <= starter_status_pkg::rate_last;
    endfunction : rate_legal

    // ------------------------------------------------------------
    // flasher for the self-diagnosis indication
    // ------------------------------------------------------------
    led_flasher #(
        .half_period(flash_half)
    ) flasher (
        .clock(clock),
        .rst(rst),
        .run(self_diagnosis),
        .phase(flash_phase)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;

        // flags are sampled every cycle, no software path reaches them
        next_state.status = '0; // see [RULE21]
        next_state.status[starter_status_pkg::bit_running] =
            motor_enabled; // see [RULE1]
        // one withdrawing source is enough to drop general enable
        next_state.status[starter_status_pkg::bit_gen_enable] =
            &source_enable; // see [RULE2]
        next_state.status[starter_status_pkg::bit_jog] =
            jog_active; // see [RULE3]
        next_state.status[starter_status_pkg::bit_init_test] =
            initial_test; // see [RULE4]
        next_state.status[starter_status_pkg::bit_ramp_up] =
            ramp_up; // see [RULE5]
        next_state.status[starter_status_pkg::bit_ramp_down] =
            ramp_down; // see [RULE5]
        next_state.status[starter_status_pkg::bit_full_volt] =
            full_voltage; // see [RULE6]
        next_state.status[starter_status_pkg::bit_bypass] =
            bypass_closed; // see [RULE7]
        next_state.status[starter_status_pkg::bit_remote] =
            remote_mode; // see [RULE8]
        next_state.status[starter_status_pkg::bit_braking] =
            braking; // see [RULE9]
        next_state.status[starter_status_pkg::bit_reversing] =
            reversal_in_progress; // see [RULE10]
        next_state.status[starter_status_pkg::bit_reverse] =
            reverse_rotation; // see [RULE11]
        next_state.status[starter_status_pkg::bit_pre_start] =
            pre_start_delay_flag; // see [RULE12]
        next_state.status[starter_status_pkg::bit_post_stop] =
            post_stop_delay_flag; // see [RULE13]
        next_state.status[starter_status_pkg::bit_alarm] =
            |alarm_codes; // see [RULE14]
        next_state.status[starter_status_pkg::bit_fault] =
            |fault_code; // see [RULE15]

        // error is sticky: only a reset (reinitialisation) clears it
        if (module_error) begin
            next_state.error_latched = 1'b1; // see [RULE17]
        end

        // error outranks diagnosis, which outranks normal operation
        if (state.error_latched || module_error) begin
            next_state.led = starter_status_pkg::led_red; // see [RULE17]
        end else if (self_diagnosis) begin
            next_state.led = flash_phase ? starter_status_pkg::led_red
                : starter_status_pkg::led_green; // see [RULE18]
        end else begin
            next_state.led = starter_status_pkg::led_green; // see [RULE16]
        end

        // single-cycle answer: waitrequest drops the cycle after the request
        // and has a flop of its own, so no inverter sits behind the pin
        next_state.waiting = 1'b1;
        next_state.resp = 2'h0;
        next_state.rdata = 32'h0000_0000;
        if ((read || write) && state.waiting) begin
            next_state.waiting = 1'b0;
            if (read) begin
                unique case (address)
                    starter_status_pkg::addr_status: begin
                        // live word, so a read sees this cycle's flags
                        next_state.rdata = {16'h0000,
                            next_state.status}; // see [RULE21]
                    end
                    starter_status_pkg::addr_alarm: begin
                        next_state.rdata = {16'h0000,
                            alarm_codes}; // see [RULE14]
                    end
                    starter_status_pkg::addr_fault: begin
                        next_state.rdata = {16'h0000,
                            fault_code}; // see [RULE15]
                    end
                    starter_status_pkg::addr_node: begin
                        next_state.rdata = {20'h0_0000, state.rate,
                            1'b0, state.node};
                    end
                    default: begin
                        next_state.resp = 2'h3; // unmapped: decode error
                    end
                endcase
            end else begin
                unique case (address)
                    starter_status_pkg::addr_status,
                    starter_status_pkg::addr_alarm,
                    starter_status_pkg::addr_fault: begin
                        // read-only words: write accepted, no effect
                    end
                    starter_status_pkg::addr_node: begin
                        if (byteenable[0]) begin
                            next_state.node = clamp_node(writedata[
                                starter_status_pkg::node_msb:
                                starter_status_pkg::node_lsb]); // see [RULE19]
                        end
                        // an illegal rate code keeps the old setting
                        if (byteenable[1] && rate_legal(writedata[
                            starter_status_pkg::rate_msb:
                            starter_status_pkg::rate_lsb])) begin
                            next_state.rate = writedata[
                                starter_status_pkg::rate_msb:
                                starter_status_pkg::rate_lsb]; // see [RULE20]
                        end
                    end
                    default: begin
                        next_state.resp = 2'h3;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= '0;
            state.waiting <= 1'b1;
            state.led <= starter_status_pkg::led_off;
            state.node <= starter_status_pkg::node_reset;
            state.rate <= starter_status_pkg::rate_reset;
        end else begin
            state <= next_state;
        end
    end

    // outputs straight from flip-flops
    assign readdata = state.rdata;
    assign waitrequest = state.waiting;
    assign response = state.resp;
    assign module_state_led = state.led;
    assign node_address = state.node;
    assign bit_rate = state.rate;
endmodule : starter_status_word_and_led
`default_nettype wire

/* verification/starter_status_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// port checks: bus answer, status word, led and settings
// ------------------------------------------------------------
module starter_status_chk #(
    parameter int source_count = 3
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // bus
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic [1:0] response,
    // drive state
    input wire logic motor_enabled,
    input wire logic [source_count-1:0] source_enable,
    input wire logic jog_active,
    input wire logic initial_test,
    input wire logic ramp_up,
    input wire logic full_voltage,
    input wire logic bypass_closed,
    input wire logic ramp_down,
    input wire logic remote_mode,
    input wire logic braking,
    input wire logic reversal_in_progress,
    input wire logic reverse_rotation,
    input wire logic pre_start_delay_flag,
    input wire logic post_stop_delay_flag,
    input wire logic [15:0] alarm_codes,
    input wire logic [15:0] fault_code,
    // health, led and settings
    input wire logic self_diagnosis,
    input wire logic module_error,
    input wire logic [1:0] module_state_led,
    input wire logic [6:0] node_address,
    input wire logic [3:0] bit_rate
);
    default clocking dc @(posedge clock);
    endclocking
    default disable iff (rst);
    logic [15:0] word_now;
    logic req;
    logic err_seen;
    // word the inputs ask for now; the read answer shows it a cycle on
    assign word_now = {|fault_code, |alarm_codes, post_stop_delay_flag,
        pre_start_delay_flag, reverse_rotation, reversal_in_progress,
        braking, remote_mode, ramp_down, bypass_closed, full_voltage,
        ramp_up, initial_test, jog_active, &source_enable, motor_enabled};
    assign req = (read || write) && waitrequest;
    // an error seen since the last reset must keep the led red, flashing
    // or not, so red is checked against this and not against the led
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            err_seen <= 1'b0;
        end else if (module_error) begin
            err_seen <= 1'b1;
        end
    end
    a_one_wait: assert property (
        req |=> !waitrequest)
        else $error("no answer one cycle after request");
    a_answer_once: assert property (
        !waitrequest |=> waitrequest)
        else $error("answer stood longer than one cycle");
    a_status_word: assert property (
        read && waitrequest && address == 4'h0
        |=> readdata == {16'h0000, $past(word_now)})
        else $error("status word differs from drive state");
    a_alarm_reg: assert property (
        read && waitrequest && address == 4'h4
        |=> readdata == {16'h0000, $past(alarm_codes)})
        else $error("alarm code readback wrong");
    a_bad_addr: assert property (
        req && address[1:0] != 2'h0 |=> response == 2'h3)
        else $error("unmapped access not refused");
    a_good_addr: assert property (
        req && address[1:0] == 2'h0 |=> response == 2'h0)
        else $error("mapped access refused");
    a_node_range: assert property (
        node_address != 7'h00)
        else $error("node address zero");
    a_rate_range: assert property (
        bit_rate <= 4'h8)
        else $error("bit rate code out of range");
    a_red_holds: assert property (
        err_seen |-> module_state_led == 2'h2)
        else $error("red left without reset");
    a_error_red: assert property (
        module_error |-> ##[1:2] module_state_led == 2'h2)
        else $error("error did not show red");
    // the sampled reset keeps the edge that releases it out of the check
    a_green_normal: assert property (
        !rst && !self_diagnosis && !module_error && !$past(module_error)
        && module_state_led != 2'h2 |=> module_state_led == 2'h1)
        else $error("normal state not green");
    c_status_read: cover property (read && address == 4'h0 && !waitrequest);
    c_flash_red: cover property (self_diagnosis && module_state_led == 2'h2);
    c_refused: cover property (!waitrequest && response == 2'h3);
endmodule : starter_status_chk
bind starter_status_word_and_led starter_status_chk #(
    .source_count(source_count)
) chk (
    .clock(clock), .rst(rst), .address(address), .read(read),
    .write(write), .readdata(readdata), .waitrequest(waitrequest),
    .response(response), .motor_enabled(motor_enabled),
    .source_enable(source_enable), .jog_active(jog_active),
    .initial_test(initial_test), .ramp_up(ramp_up),
    .full_voltage(full_voltage), .bypass_closed(bypass_closed),
    .ramp_down(ramp_down), .remote_mode(remote_mode), .braking(braking),
    .reversal_in_progress(reversal_in_progress),
    .reverse_rotation(reverse_rotation),
    .pre_start_delay_flag(pre_start_delay_flag),
    .post_stop_delay_flag(post_stop_delay_flag),
    .alarm_codes(alarm_codes), .fault_code(fault_code),
    .self_diagnosis(self_diagnosis), .module_error(module_error),
    .module_state_led(module_state_led), .node_address(node_address),
    .bit_rate(bit_rate)
);
`default_nettype wire

/* verification/field_master.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// network master side: one node, one rate, byte lanes taken from lanes
// ------------------------------------------------------------
module field_master (
    // clock
    input wire logic clock,
    // byte lanes to enable on the next request
    input wire logic [3:0] lanes,
    // bus
    output logic [3:0] address,
    output logic read,
    output logic write,
    output logic [31:0] writedata,
    output logic [3:0] byteenable,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic [1:0] response,
    // raised when an answer never came
    output logic hung
);
    // single node on this bus, so its address is distinct by itself
    initial begin
        address = 4'h0;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0000_0000;
        byteenable = 4'hF;
        hung = 1'b0;
    end
    // request held until waitrequest is seen low; released lines invert
    task automatic xfer(input logic wr, input logic [3:0] a,
            input logic [31:0] d, output logic [31:0] q,
            output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clock);
        address <= a;
        read <= !wr;
        write <= wr;
        writedata <= d;
        byteenable <= lanes;
        @(posedge clock);
        while (waitrequest && n < 40) begin
            n++;
            @(posedge clock);
        end
        hung = hung | waitrequest; // the caller looks at it at once
        q = readdata;
        r = response;
        read <= 1'b0;
        write <= 1'b0;
        address <= ~a;
        writedata <= ~d;
    endtask : xfer
endmodule : field_master
`default_nettype wire

/* verification/starter_status_word_and_led_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// status word, node settings and led sequences
// ------------------------------------------------------------
module starter_status_word_and_led_tb_top;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [3:0] address, byteenable;
    logic read, write, waitrequest, hung, self_diagnosis, module_error;
    logic [31:0] writedata, readdata, q;
    logic [1:0] response, r, module_state_led;
    logic [15:0] drv, alarm_codes, fault_code;
    logic [2:0] source_enable;
    logic [6:0] node_address;
    logic [3:0] bit_rate;
    logic [3:0] lanes = 4'hF;
    int mismatches = 0;
    int checks = 0;
    int ng, nr;
    always #10 clock = ~clock;
    field_master m (.clock(clock), .lanes(lanes), .address(address),
        .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest),
        .response(response), .hung(hung));
    starter_status_word_and_led #(.flash_half(4)) uut (.clock(clock),
        .rst(rst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest),
        .response(response), .motor_enabled(drv[0]),
        .source_enable(source_enable), .jog_active(drv[2]),
        .initial_test(drv[3]), .ramp_up(drv[4]), .full_voltage(drv[5]),
        .bypass_closed(drv[6]), .ramp_down(drv[7]), .remote_mode(drv[8]),
        .braking(drv[9]), .reversal_in_progress(drv[10]),
        .reverse_rotation(drv[11]), .pre_start_delay_flag(drv[12]),
        .post_stop_delay_flag(drv[13]), .alarm_codes(alarm_codes),
        .fault_code(fault_code), .self_diagnosis(self_diagnosis),
        .module_error(module_error), .module_state_led(module_state_led),
        .node_address(node_address), .bit_rate(bit_rate));
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : print_verdict
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : check
    // a lost answer ends the run at once
    task automatic acc(input logic wr, input logic [3:0] a,
            input logic [31:0] d);
        m.xfer(wr, a, d, q, r);
        if (hung !== 1'b0) begin
            mismatches++;
            print_verdict();
        end
    endtask : acc
    task automatic set_flags(input logic [15:0] v, input logic [2:0] s);
        @(posedge clock);
        drv <= v;
        source_enable <= s;
        alarm_codes <= {v[14], 15'h0000};
        fault_code <= {15'h0000, v[15]};
    endtask : set_flags
    task automatic led_run(input int n);
        ng = 0;
        nr = 0;
        repeat (n) begin
            @(posedge clock);
            ng += int'(module_state_led === 2'h1);
            nr += int'(module_state_led === 2'h2);
        end
    endtask : led_run
    initial begin
        drv = 16'h0000;
        source_enable = 3'h0;
        alarm_codes = 16'h0000;
        fault_code = 16'h0000;
        self_diagnosis = 1'b0;
        module_error = 1'b0;
        repeat (4) @(posedge clock);
        check({bit_rate, node_address, module_state_led},
            13'h0004);
        rst <= 1'b0;
        led_run(3);
        check(module_state_led, 2'h1);
        // walking one, then all set and all clear
        for (int i = 0; i < 18; i++) begin
            set_flags(i < 16 ? 16'h0001 << i : (i == 16 ? 16'hFFFF : 0),
                i == 1 || i == 16 ? 3'h7 : 3'h0);
            acc(1'b0, 4'h0, 32'h0);
            check(q, i < 16 ? 32'h1 << i // to
                : (i == 16 ? 32'hFFFF : 0));
        end
        set_flags(16'hC002, 3'h5);
        acc(1'b0, 4'h0, 32'h0);
        check(q, 32'h0000_C000);
        acc(1'b0, 4'h4, 32'h0);
        check(q, 32'h0000_8000);
        acc(1'b0, 4'h8, 32'h0);
        check(q, 32'h0000_0001);
        acc(1'b1, 4'h0, 32'hFFFF_FFFF);
        acc(1'b0, 4'h0, 32'h0);
        check(q, 32'h0000_C000);
        check(r, 2'h0);
        acc(1'b1, 4'hE, 32'h0000_0305);
        check({r, node_address}, 9'h181);
        acc(1'b0, 4'h6, 32'h0);
        check(r, 2'h3);
        // every rate code with a different node each time
        for (int k = 0; k <= 8; k++) begin
            acc(1'b1, 4'hC, {20'h0, 4'(k), 1'b0, 7'(k * 15 + 7)});
            acc(1'b0, 4'hC, 32'h0);
            check(q, {20'h0, 4'(k), 1'b0, 7'(k * 15 + 7)});
        end
        acc(1'b1, 4'hC, 32'h0000_0900);
        check({bit_rate, node_address}, 11'h401);
        acc(1'b1, 4'hC, 32'h0000_037F);
        check({bit_rate, node_address}, 11'h1FF);
        // only the enabled byte lane may change its setting
        lanes <= 4'h1;
        acc(1'b1, 4'hC, 32'h0000_0533);
        check({bit_rate, node_address}, 11'h1B3);
        lanes <= 4'h2;
        acc(1'b1, 4'hC, 32'h0000_0611);
        check({bit_rate, node_address}, 11'h333);
        lanes <= 4'hF;
        @(posedge clock);
        self_diagnosis <= 1'b1;
        led_run(20);
        check({ng > 5, nr > 5}, 2'h3);
        self_diagnosis <= 1'b0;
        led_run(3);
        check(module_state_led, 2'h1);
        module_error <= 1'b1;
        @(posedge clock);
        module_error <= 1'b0;
        self_diagnosis <= 1'b1;
        led_run(12);
        check(nr, 12);
        rst <= 1'b1;
        self_diagnosis <= 1'b0;
        @(posedge clock);
        rst <= 1'b0;
        led_run(3);
        check({module_state_led, node_address}, 9'h081);
        print_verdict();
    end
endmodule : starter_status_word_and_led_tb_top
`default_nettype wire
